// *** testbench/sus_top_chk.sv ***
// Port-level assertions for the serial stop unit
`timescale 1ns/10ps
module sus_chk
	import sus_pkg::*;
(
	// Clock and reset
	input wire logic            clk,
	input wire logic            srst,
	// Register bus
	input wire logic [AW-1:0]   avs_address,
	input wire logic            avs_read,
	input wire logic            avs_write,
	input wire logic [DW-1:0]   avs_writedata,
	input wire logic [3:0]      avs_byteenable,
	input wire logic            avs_waitrequest,
	// Serial side
	input wire logic            slave_select_pin,
	input wire logic [NCH-1:0]  ser_data_in,
	input wire logic [NCH-1:0]  ser_clk_in,
	input wire logic [NCH-1:0]  chan_run,
	input wire logic            transfer_permit0,
	input wire logic            serial_unit_clock_on,
	input wire logic [7:0]      peripheral_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	logic acc;
	assign acc = avs_write & ~avs_waitrequest & avs_byteenable[0];

	// ====================
	// Properties
	// ====================
	sequence s_req; $rose(avs_read | avs_write); endsequence
	sequence s_ans; avs_waitrequest ##1 !avs_waitrequest; endsequence
	property p_bus_wait; s_req |-> s_ans; endproperty
	property p_unit_clk;
		acc && avs_address == OFS_PER_CLK |=> peripheral_enable == $past(avs_writedata[7:0])
			&& serial_unit_clock_on == $past(avs_writedata[BIT_UNIT_CLOCK]);
	endproperty
	property p_run_gate; (chan_run != '0) |-> serial_unit_clock_on; endproperty
	// Each stopped channel must see idle inputs, whatever the others do
	property p_idle_in; (ser_data_in | chan_run) == '1 && (ser_clk_in | chan_run) == '1; endproperty
	property p_permit_run; transfer_permit0 |-> chan_run[0]; endproperty
	property p_permit_low; chan_run[0] && !slave_select_pin |-> transfer_permit0; endproperty
	property p_stop_clear;
		acc && avs_address == OFS_STOP_TRIG |=> (chan_run & $past(avs_writedata[NCH-1:0])) == '0;
	endproperty
	property p_status_ro; acc && avs_address == OFS_ENABLE_STAT |=> $stable(chan_run); endproperty

	a_bus_wait: assert property (p_bus_wait)
		else $error("bus answer not after one wait cycle");
	a_unit_clk: assert property (p_unit_clk)
		else $error("peripheral enable does not show written value");
	a_run_gate: assert property (p_run_gate)
		else $error("channel runs with unit clock off");
	a_idle_in: assert property (p_idle_in)
		else $error("stopped channel sees pin input");
	a_permit_run: assert property (p_permit_run)
		else $error("transfer permitted on stopped channel");
	a_permit_low: assert property (p_permit_low)
		else $error("transfer blocked with select low");
	a_stop_clear: assert property (p_stop_clear)
		else $error("stop write did not clear channel");
	a_status_ro: assert property (p_status_ro)
		else $error("status changed by direct write");
endmodule

bind sus_top sus_chk chk_u (
	.clk                  (clk),
	.srst                 (srst),
	.avs_address          (avs_address),
	.avs_read             (avs_read),
	.avs_write            (avs_write),
	.avs_writedata        (avs_writedata),
	.avs_byteenable       (avs_byteenable),
	.avs_waitrequest      (avs_waitrequest),
	.slave_select_pin     (slave_select_pin),
	.ser_data_in          (ser_data_in),
	.ser_clk_in           (ser_clk_in),
	.chan_run             (chan_run),
	.transfer_permit0     (transfer_permit0),
	.serial_unit_clock_on (serial_unit_clock_on),
	.peripheral_enable    (peripheral_enable)
);

// *** testbench/tb_sus_top.sv ***
// Self-checking bench for the serial stop unit
`timescale 1ns/10ps
module tb_sus_top
	import sus_pkg::*;
;
	logic            clk, srst, avs_read, avs_write, avs_waitrequest, seen;
	logic            slave_select_pin, transfer_permit0, serial_unit_clock_on;
	logic [AW-1:0]   avs_address;
	logic [DW-1:0]   avs_writedata, avs_readdata, q;
	logic [NPIN-1:0] pin_in, pin_out, pin_oe, pin_ttl_select;
	logic [NCH-1:0]  eng_data_out, eng_clk_out, ser_data_in, ser_clk_in, chan_run;
	logic [7:0]      peripheral_enable;
	logic [3:0]      avs_byteenable;
	int              fails, total_checks, r, p, f;
	int              m_flt, m_per, m_isc, m_soe, m_lvl, m_st, m_mode, m_dir, m_lat, m_ib, m_dr;

	sus_top dut_u (
		.clk                  (clk),
		.srst                 (srst),
		.avs_address          (avs_address),
		.avs_read             (avs_read),
		.avs_write            (avs_write),
		.avs_writedata        (avs_writedata),
		.avs_byteenable       (avs_byteenable),
		.avs_readdata         (avs_readdata),
		.avs_waitrequest      (avs_waitrequest),
		.pin_in               (pin_in),
		.pin_out              (pin_out),
		.pin_oe               (pin_oe),
		.pin_ttl_select       (pin_ttl_select),
		.slave_select_pin     (slave_select_pin),
		.eng_data_out         (eng_data_out),
		.eng_clk_out          (eng_clk_out),
		.ser_data_in          (ser_data_in),
		.ser_clk_in           (ser_clk_in),
		.chan_run             (chan_run),
		.transfer_permit0     (transfer_permit0),
		.serial_unit_clock_on (serial_unit_clock_on),
		.peripheral_enable    (peripheral_enable)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ====================
	// Checking and bus
	// ====================
	task automatic results();
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [DW-1:0] exp, input logic [DW-1:0] got);
		total_checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask

	task automatic bus(input logic [AW-1:0] a, input logic w, input logic [DW-1:0] d);
		int n;
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		if (n >= 64) begin
			$display("ERROR waitrequest expected 0 seen 1");
			fails++;
			results();
		end
	endtask

	// ====================
	// Register model
	// ====================
	task automatic wr(input int a, input int d);
		bit ck;
		int wm;
		ck = m_per[BIT_UNIT_CLOCK];
		wm = (~m_soe & 'hF) | ((~m_st & 'hF) << 8);
		bus(a[AW-1:0], 1'b1, d);
		// Only the level register is ever written without lane 0
		if (!avs_byteenable[0]) wm = wm & 'hFF00;
		case (a)
			'h00: m_flt = d & RX_FILTER_MASK;
			'h04: m_per = d & 'hFF;
			'h08: m_isc = d & 'h80;
			'h0C: if (ck) m_soe = d & 'hF;
			'h10: if (ck) m_lvl = (m_lvl & ~wm) | (d & wm);
			'h14: if (ck) m_st = m_st & ~d;
			'h18: if (ck) m_st = m_st | (d & 'hF);
			'h20: m_mode = d & 'hFF;
			'h24: m_dir = d & 'hFF;
			'h28: m_lat = d & 'hFF;
			'h2C: m_ib = d & 'hFF;
			'h30: m_dr = d & 'hFF;
			default: ;
		endcase
	endtask

	function automatic int mdl_rd(input int a);
		bit ck;
		ck = m_per[BIT_UNIT_CLOCK];
		case (a)
			'h00: return m_flt;
			'h04: return m_per;
			'h08: return m_isc;
			'h0C: return ck ? m_soe : 0;
			'h10: return ck ? m_lvl : 'h0F0F;
			'h1C: return ck ? m_st : 0;
			'h20: return m_mode;
			'h24: return m_dir;
			'h28: return m_lat;
			'h2C: return m_ib;
			'h30: return m_dr;
			default: return 0;
		endcase
	endfunction

	task automatic rd(input int a);
		bus(a[AW-1:0], 1'b0, '0);
		chk("readdata", mdl_rd(a), q);
	endtask

	task automatic rd_all();
		for (int a = 0; a <= 'h38; a += 4)
			if (a != 'h18 && a != 'h34)
				rd(a);
	endtask

	task automatic chk_pins();
		logic [DW-1:0] oe, po, si, sg;
		logic          run, lvl, v;
		int            n;
		repeat (2) @(posedge clk);
		oe = '0;
		po = '0;
		si = '0;
		sg = '0;
		for (int i = 0; i < NPIN; i++) begin
			n = i / 2;
			run = m_st[n] & m_per[BIT_UNIT_CLOCK];
			if (i % 2)
				lvl = run ? eng_clk_out[n] : m_lvl[8 + n];
			else
				lvl = (run && m_soe[n]) ? eng_data_out[n] : m_lvl[n];
			v = m_lat[i] & lvl;
			oe[i] = !m_mode[i] && !m_dir[i] && (!m_dr[i] || !v);
			po[i] = v;
			si[i] = (run && m_dir[i] && !m_mode[i]) ? pin_in[i] : 1'b1;
			sg[i] = (i % 2) ? ser_clk_in[n] : ser_data_in[n];
		end
		chk("pin_oe", oe, DW'(pin_oe));
		chk("pin_out", po & oe, DW'(pin_out & pin_oe));
		chk("pin_ttl_select", m_ib, DW'(pin_ttl_select));
		chk("chan_run", m_per[BIT_UNIT_CLOCK] ? m_st : 0, DW'(chan_run));
		chk("ser_in", si, sg);
	endtask

	// ====================
	// Main sequence
	// ====================
	initial begin
		srst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata, slave_select_pin} = '0;
		{pin_in, eng_data_out, eng_clk_out} = '0;
		{fails, total_checks, m_flt, m_per, m_isc, m_soe, m_st, m_lat, m_ib, m_dr} = '0;
		m_lvl = 'h0F0F;
		avs_byteenable = 4'hF;
		m_mode = 'hFF;
		m_dir = 'hFF;
		r = $urandom(32'h4e26e638);
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd_all();
		// Unit clock off: only the filter, switch and port registers take writes
		for (int a = 0; a <= 'h38; a += 4)
			if (a != 'h04 && a != 'h34)
				wr(a, $urandom & (a == 0 ? 'h05 : (a == 8 ? 'h80 : 'hFFFF)));
		rd_all();
		chk_pins();
		wr('h04, 'h04);
		@(posedge clk);
		chk("serial_unit_clock_on", 1, DW'(serial_unit_clock_on));
		chk("peripheral_enable", m_per, DW'(peripheral_enable));
		wr('h0C, 'hF);
		wr('h18, 'hF);
		wr('h1C, 0);
		rd('h1C);
		wr('h10, 0);
		rd('h10);
		wr('h0C, 0);
		wr('h10, 0);
		rd('h10);
		wr('h14, 5);
		chk_pins();
		rd('h14);
		rd('h1C);
		wr('h14, 0);
		wr('h10, 'hFFFF);
		rd('h10);
		avs_byteenable <= 4'h2;
		wr('h10, 0);
		avs_byteenable <= 4'hF;
		rd('h10);
		repeat (10) begin
			eng_data_out <= 4'($urandom);
			eng_clk_out <= 4'($urandom);
			for (int a = 'h20; a <= 'h30; a += 4)
				wr(a, $urandom & 'hFF);
			wr('h0C, $urandom & 'hF);
			wr('h18, $urandom & 'hF);
			wr('h14, $urandom & 'hF);
			wr('h10, $urandom & 'h0F0F);
			chk_pins();
		end
		wr('h18, 1);
		repeat (8) begin
			wr('h08, $urandom & 'h80);
			slave_select_pin <= 1'($urandom);
			repeat (2) @(posedge clk);
			chk("transfer_permit0", DW'(m_st[0] & (!m_isc[7] | !slave_select_pin)), DW'(transfer_permit0));
		end
		// One-cycle glitch must pass only with the filter off
		wr('h20, 0);
		wr('h24, 'hFF);
		wr('h18, 'hF);
		for (int k = 0; k < 4; k++) begin
			p = k[1] ? RX1_PIN : RX0_PIN;
			f = k[0];
			wr('h00, f << (k[1] ? BIT_UART1_FILTER : BIT_UART0_FILTER));
			pin_in[p] <= 1'b0;
			repeat (8) @(posedge clk);
			chk("ser_data_in", 0, DW'(ser_data_in[p / 2]));
			pin_in[p] <= 1'b1;
			@(posedge clk);
			pin_in[p] <= 1'b0;
			seen = 1'b0;
			repeat (8) begin
				@(posedge clk);
				seen = seen | ser_data_in[p / 2];
			end
			chk("glitch seen", DW'(f == 0), DW'(seen));
			pin_in[p] <= 1'b1;
			repeat (8) @(posedge clk);
			chk("ser_data_in", 1, DW'(ser_data_in[p / 2]));
		end
		results();
	end
endmodule

// *** verilog/sus_in_filter.sv ***
// Input synchroniser with optional two-clock match noise filter
`timescale 1ns/10ps
module sus_in_filter
	import sus_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// Control and data
	input  wire logic filt_on,
	input  wire logic raw,
	output logic      clean
);

	// ==========================================================================
	// State
	// ==========================================================================
	sus_filt_s q;
	sus_filt_s d;

	always_comb begin
		d         = q;
		d.sync[0] = raw;
		d.sync[1] = q.sync[0];
		d.prev    = q.sync[1];
		if (filt_on) begin
			// Accept a level only after it matched on two consecutive clocks
			if (q.sync[1] == q.prev) begin
				d.clean = q.sync[1];
			end
		end else begin
			d.clean = q.sync[1];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '{sync: {FILT_IDLE, FILT_IDLE}, prev: FILT_IDLE, clean: FILT_IDLE};
		end else begin
			q <= d;
		end
	end

	assign clean = q.clean;

endmodule

// *** verilog/sus_pkg.sv ***
// Package: register map, field layout, reset values and state types of the serial stop unit
package sus_pkg;

	// ==========================================================================
	// Geometry
	// ==========================================================================
	localparam int NCH   = 4;
	localparam int NPIN  = 8;
	localparam int AW    = 8;
	localparam int DW    = 32;

	// Shared pin layout: channel n uses pin 2n for data, pin 2n+1 for clock
	localparam int RX0_PIN = 2;
	localparam int RX1_PIN = 6;

	// ==========================================================================
	// Register byte offsets
	// ==========================================================================
	localparam logic [AW-1:0] OFS_RX_FILTER    = 8'h00;
	localparam logic [AW-1:0] OFS_PER_CLK      = 8'h04;
	localparam logic [AW-1:0] OFS_INPUT_SWITCH = 8'h08;
	localparam logic [AW-1:0] OFS_OUT_ENABLE   = 8'h0C;
	localparam logic [AW-1:0] OFS_OUT_LEVEL    = 8'h10;
	localparam logic [AW-1:0] OFS_STOP_TRIG    = 8'h14;
	localparam logic [AW-1:0] OFS_START_TRIG   = 8'h18;
	localparam logic [AW-1:0] OFS_ENABLE_STAT  = 8'h1C;
	localparam logic [AW-1:0] OFS_PIN_MODE     = 8'h20;
	localparam logic [AW-1:0] OFS_PIN_DIR      = 8'h24;
	localparam logic [AW-1:0] OFS_PORT_LATCH   = 8'h28;
	localparam logic [AW-1:0] OFS_PIN_INBUF    = 8'h2C;
	localparam logic [AW-1:0] OFS_PIN_DRIVE    = 8'h30;
	localparam logic [AW-1:0] OFS_PIN_LEVEL    = 8'h34;

	// ==========================================================================
	// Field positions and masks
	// ==========================================================================
	localparam int BIT_UART0_FILTER = 0;
	localparam int BIT_UART1_FILTER = 2;
	localparam int BIT_UNIT_CLOCK   = 2;
	localparam int BIT_SS_ENABLE    = 7;
	localparam int CKO_LSB          = 8;
	localparam logic [7:0]  RX_FILTER_MASK = 8'h05;
	localparam logic [15:0] OUT_LEVEL_MASK = 16'h0F0F;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic [7:0]     RST_RX_FILTER  = 8'h00;
	localparam logic [7:0]     RST_PER_CLK    = 8'h00;
	localparam logic           RST_SS_ENABLE  = 1'h0;
	localparam logic [NCH-1:0] RST_OUT_ENABLE = 4'h0;
	localparam logic [15:0]    RST_OUT_LEVEL  = 16'h0F0F;
	localparam logic [NCH-1:0] RST_ENABLE     = 4'h0;
	localparam logic [7:0]     RST_PIN_MODE   = 8'hFF;
	localparam logic [7:0]     RST_PIN_DIR    = 8'hFF;
	localparam logic [7:0]     RST_PORT_LATCH = 8'h00;
	localparam logic [7:0]     RST_PIN_INBUF  = 8'h00;
	localparam logic [7:0]     RST_PIN_DRIVE  = 8'h00;

	// ==========================================================================
	// State types
	// ==========================================================================
	typedef struct packed {
		logic [7:0]      rx_filter_enable;
		logic [7:0]      peripheral_clock_enable;
		logic            slave_select_input_enable;
		logic [NCH-1:0]  serial_output_enable;
		logic [15:0]     serial_output_level;
		logic [NCH-1:0]  channel_stop_trigger;
		logic [NCH-1:0]  channel_enable_status;
		logic [NPIN-1:0] pin_mode_control;
		logic [NPIN-1:0] pin_direction;
		logic [NPIN-1:0] port_latch;
		logic [NPIN-1:0] pin_input_buffer_select;
		logic [NPIN-1:0] pin_output_drive_select;
		logic [NPIN-1:0] pin_out;
		logic [NPIN-1:0] pin_oe;
		logic            ack;
		logic [DW-1:0]   rdata;
	} sus_regs_s;

	typedef struct packed {
		logic [1:0] sync;
		logic       prev;
		logic       clean;
	} sus_filt_s;

	localparam logic FILT_IDLE = 1'h1;

endpackage

// *** verilog/sus_top.sv ***
// Serial unit stop control, pin function routing and receive noise filtering
`timescale 1ns/10ps

// How it works
// - First receive pin filter bit: 0 turns filter off, 1 turns it on.
// - Filter on: synchronise, then accept after two matching clocks; off: synchronise only.
// - Pin drives serial output only with mode and direction 0, latch 1.
// - Pin delivers serial input when direction 1 and mode 0, any latch.
// - Output drive bit 1 makes the serial output open-drain, low only.
// - Input buffer bit 1 selects the TTL threshold input buffer.
// - Stopped channel does not communicate; its pins act as port pins.
// - Peripheral enable bit 2 gates the whole unit's input clock.
// - Unit clock bit 0 stops the clock, 1 supplies it.
// - Unit clock off: control register writes ignored, reads give reset values.
// - Input switch, filter and port registers stay usable with clock off.
// - Stop bit is a trigger; it clears itself once enable status is 0.
// - Enable status is read-only, cleared only through the stop trigger.
// - Clock output level bit is writable only while the channel is stopped.
// - Data output level bit is writable only while serial output is off.
// - Slave-select enable 0 ignores the slave-select pin.
// - Slave-select high blocks transfer; low permits it per mode settings.
module sus_top
	import sus_pkg::*;
(
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            srst,
	// Avalon-MM slave
	input  wire logic [AW-1:0]   avs_address,
	input  wire logic            avs_read,
	input  wire logic            avs_write,
	input  wire logic [DW-1:0]   avs_writedata,
	input  wire logic [3:0]      avs_byteenable,
	output logic [DW-1:0]        avs_readdata,
	output logic                 avs_waitrequest,
	// Shared port pins
	input  wire logic [NPIN-1:0] pin_in,
	output logic [NPIN-1:0]      pin_out,
	output logic [NPIN-1:0]      pin_oe,
	output logic [NPIN-1:0]      pin_ttl_select,
	input  wire logic            slave_select_pin,
	// Transfer engine side
	input  wire logic [NCH-1:0]  eng_data_out,
	input  wire logic [NCH-1:0]  eng_clk_out,
	output logic [NCH-1:0]       ser_data_in,
	output logic [NCH-1:0]       ser_clk_in,
	output logic [NCH-1:0]       chan_run,
	output logic                 transfer_permit0,
	output logic                 serial_unit_clock_on,
	output logic [7:0]           peripheral_enable
);

	// ==========================================================================
	// Helpers
	// ==========================================================================
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_val,
		input logic [DW-1:0] wdata,
		input logic [3:0] be
	);
		logic [15:0] res;
		res = old_val;
		if (be[0]) begin
			res[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			res[15:8] = wdata[15:8];
		end
		return res;
	endfunction

	function automatic logic [DW-1:0] zext8(input logic [7:0] v);
		return {24'h000000, v};
	endfunction

	// ==========================================================================
	// State
	// ==========================================================================
	sus_regs_s q;
	sus_regs_s d;

	logic            unit_on;
	logic            access;
	logic            wr_take;
	logic [AW-1:0]   word_addr;
	logic [15:0]     wr16;
	logic [NCH-1:0]  run_eff;
	logic [NPIN-1:0] filt_on;
	logic [NPIN-1:0] clean;
	logic [NPIN-1:0] in_ok;
	logic [NPIN-1:0] nxt_out;
	logic [NPIN-1:0] nxt_oe;
	logic [15:0]     lvl_wr;
	logic [DW-1:0]   rd_val;

	assign unit_on   = q.peripheral_clock_enable[BIT_UNIT_CLOCK];
	assign access    = avs_read | avs_write;
	assign wr_take   = avs_write & q.ack;
	assign word_addr = {avs_address[AW-1:2], 2'b00};
	assign wr16      = lane_merge(16'h0000, avs_writedata, avs_byteenable);
	// Channels only operate while the unit clock is supplied
	assign run_eff   = q.channel_enable_status & {NCH{unit_on}};

	// ==========================================================================
	// Receive filters, one per shared pin
	// ==========================================================================
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			localparam int CH    = gi / 2;
			localparam bit IS_CK = (gi % 2) == 1;

			if (gi == RX0_PIN) begin : g_rx0
				assign filt_on[gi] = q.rx_filter_enable[BIT_UART0_FILTER];
			end else if (gi == RX1_PIN) begin : g_rx1
				assign filt_on[gi] = q.rx_filter_enable[BIT_UART1_FILTER];
			end else begin : g_nofilt
				assign filt_on[gi] = 1'b0;
			end

			sus_in_filter u_filt (
				.clk     (clk),
				.srst    (srst),
				.filt_on (filt_on[gi]),
				.raw     (pin_in[gi]),
				.clean   (clean[gi])
			);

			// Input path: direction 1, mode control 0; the latch plays no part
			assign in_ok[gi] = q.pin_direction[gi] & ~q.pin_mode_control[gi];

			logic ser_lvl;
			logic drv_val;
			logic drive;
			if (IS_CK) begin : g_ck
				assign ser_lvl = run_eff[CH] ? eng_clk_out[CH]
				                             : q.serial_output_level[CKO_LSB + CH];
			end else begin : g_dt
				assign ser_lvl = (run_eff[CH] & q.serial_output_enable[CH]) ? eng_data_out[CH]
				                                                           : q.serial_output_level[CH];
			end
			// With latch 0 the pin just drives a port low; latch 1 lets the serial level through
			assign drv_val     = q.port_latch[gi] & ser_lvl;
			assign drive       = ~q.pin_mode_control[gi] & ~q.pin_direction[gi];
			assign nxt_out[gi] = drv_val;
			// Open-drain only pulls low; a high level releases the pin
			assign nxt_oe[gi]  = drive & (~q.pin_output_drive_select[gi] | ~drv_val);
		end
	endgenerate

	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			assign ser_data_in[gi] = (in_ok[2*gi] & run_eff[gi]) ? clean[2*gi] : FILT_IDLE;
			assign ser_clk_in[gi]  = (in_ok[2*gi+1] & run_eff[gi]) ? clean[2*gi+1] : FILT_IDLE;
		end
	endgenerate

	// ==========================================================================
	// Output level write mask
	// ==========================================================================
	always_comb begin
		lvl_wr = 16'h0000;
		for (int n = 0; n < NCH; n++) begin
			lvl_wr[CKO_LSB + n] = ~q.channel_enable_status[n];
			lvl_wr[n]           = ~q.serial_output_enable[n];
		end
	end

	// ==========================================================================
	// Read mux
	// ==========================================================================
	always_comb begin
		rd_val = '0;
		unique case (word_addr)
			OFS_RX_FILTER: begin
				rd_val = zext8(q.rx_filter_enable);
			end
			OFS_PER_CLK: begin
				rd_val = zext8(q.peripheral_clock_enable);
			end
			OFS_INPUT_SWITCH: begin
				rd_val[BIT_SS_ENABLE] = q.slave_select_input_enable;
			end
			OFS_OUT_ENABLE: begin
				rd_val[NCH-1:0] = unit_on ? q.serial_output_enable : RST_OUT_ENABLE;
			end
			OFS_OUT_LEVEL: begin
				rd_val[15:0] = unit_on ? q.serial_output_level : RST_OUT_LEVEL;
			end
			OFS_STOP_TRIG: begin
				rd_val[NCH-1:0] = unit_on ? q.channel_stop_trigger : 4'h0;
			end
			OFS_ENABLE_STAT: begin
				rd_val[NCH-1:0] = unit_on ? q.channel_enable_status : RST_ENABLE;
			end
			OFS_PIN_MODE: begin
				rd_val = zext8(q.pin_mode_control);
			end
			OFS_PIN_DIR: begin
				rd_val = zext8(q.pin_direction);
			end
			OFS_PORT_LATCH: begin
				rd_val = zext8(q.port_latch);
			end
			OFS_PIN_INBUF: begin
				rd_val = zext8(q.pin_input_buffer_select);
			end
			OFS_PIN_DRIVE: begin
				rd_val = zext8(q.pin_output_drive_select);
			end
			OFS_PIN_LEVEL: begin
				rd_val = zext8(clean);
			end
			default: begin
				rd_val = '0;
			end
		endcase
	end

	// ==========================================================================
	// Next state
	// ==========================================================================
	always_comb begin
		logic [15:0] lvl_new;
		lvl_new = lane_merge(q.serial_output_level, avs_writedata, avs_byteenable);
		d = q;

		// One wait cycle per access; read data latched on the first cycle
		d.ack = access & ~q.ack;
		if (avs_read & ~q.ack) begin
			d.rdata = rd_val;
		end

		// A stop bit falls as soon as its channel reports stopped
		d.channel_stop_trigger = q.channel_stop_trigger & q.channel_enable_status;

		if (wr_take & avs_byteenable[0]) begin
			unique case (word_addr)
				OFS_RX_FILTER: begin
					// Unused positions are kept at zero
					d.rx_filter_enable = wr16[7:0] & RX_FILTER_MASK;
				end
				OFS_PER_CLK: begin
					d.peripheral_clock_enable = wr16[7:0];
				end
				OFS_INPUT_SWITCH: begin
					d.slave_select_input_enable = wr16[BIT_SS_ENABLE];
				end
				OFS_OUT_ENABLE: begin
					if (unit_on) begin
						d.serial_output_enable = wr16[NCH-1:0];
					end
				end
				OFS_STOP_TRIG: begin
					if (unit_on) begin
						// Zeros written here change nothing
						d.channel_enable_status = q.channel_enable_status & ~wr16[NCH-1:0];
						d.channel_stop_trigger  = q.channel_enable_status & wr16[NCH-1:0];
					end
				end
				OFS_START_TRIG: begin
					if (unit_on) begin
						d.channel_enable_status = q.channel_enable_status | wr16[NCH-1:0];
					end
				end
				OFS_PIN_MODE: begin
					d.pin_mode_control = wr16[7:0];
				end
				OFS_PIN_DIR: begin
					d.pin_direction = wr16[7:0];
				end
				OFS_PORT_LATCH: begin
					d.port_latch = wr16[7:0];
				end
				OFS_PIN_INBUF: begin
					d.pin_input_buffer_select = wr16[7:0];
				end
				OFS_PIN_DRIVE: begin
					d.pin_output_drive_select = wr16[7:0];
				end
				default: begin
				end
			endcase
		end

		// Level register spans two lanes; byte 1 alone may also update it
		if (wr_take & (word_addr == OFS_OUT_LEVEL) & unit_on) begin
			d.serial_output_level = ((lvl_new & lvl_wr) | (q.serial_output_level & ~lvl_wr))
			                        & OUT_LEVEL_MASK | (RST_OUT_LEVEL & ~OUT_LEVEL_MASK);
		end

		d.pin_out = nxt_out;
		d.pin_oe  = nxt_oe;
	end

	// ==========================================================================
	// Registers
	// ==========================================================================
	always_ff @(posedge clk) begin
		if (srst) begin
			q.rx_filter_enable          <= RST_RX_FILTER;
			q.peripheral_clock_enable   <= RST_PER_CLK;
			q.slave_select_input_enable <= RST_SS_ENABLE;
			q.serial_output_enable      <= RST_OUT_ENABLE;
			q.serial_output_level       <= RST_OUT_LEVEL;
			q.channel_stop_trigger      <= 4'h0;
			q.channel_enable_status     <= RST_ENABLE;
			q.pin_mode_control          <= RST_PIN_MODE;
			q.pin_direction             <= RST_PIN_DIR;
			q.port_latch                <= RST_PORT_LATCH;
			q.pin_input_buffer_select   <= RST_PIN_INBUF;
			q.pin_output_drive_select   <= RST_PIN_DRIVE;
			q.pin_out                   <= 8'h00;
			q.pin_oe                    <= 8'h00;
			q.ack                       <= 1'b0;
			q.rdata                     <= 32'h00000000;
		end else begin
			q <= d;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	assign avs_waitrequest      = access & ~q.ack;
	assign avs_readdata         = q.rdata;
	assign pin_out              = q.pin_out;
	assign pin_oe               = q.pin_oe;
	assign pin_ttl_select       = q.pin_input_buffer_select;
	assign chan_run             = run_eff;
	assign serial_unit_clock_on = unit_on;
	assign peripheral_enable    = q.peripheral_clock_enable;
	// Pin ignored while disabled; a high level blocks channel 0 transfers
	assign transfer_permit0     = run_eff[0]
	                              & (~q.slave_select_input_enable | ~slave_select_pin);

endmodule
